// ===== ifc_pkg.sv
// package: register map, field layout and timing constants for the isp flash control block
package ifc_pkg;
   // register indices (wishbone byte addresses are index * 4)
   localparam logic [7:0] IFC_IDX_SPC = 8'hbf; // system_programming_control
   localparam logic [7:0] IFC_IDX_CMD = 8'hc7; // flash_command_byte
   localparam logic [7:0] IFC_IDX_AH = 8'hc4; // flash_target_address_high
   localparam logic [7:0] IFC_IDX_AL = 8'hc5; // flash_target_address_low
   localparam logic [7:0] IFC_IDX_FD = 8'hc6; // flash_data_byte
   localparam logic [7:0] IFC_IDX_KEY = 8'hf6; // control_unlock_key
   localparam logic [7:0] IFC_IDX_IDLE = 8'hc8; // idle entry / wake control and status
   // unlock key sequence
   localparam logic [7:0] IFC_KEY1 = 8'h87;
   localparam logic [7:0] IFC_KEY2 = 8'h59;
   // system programming control bits
   localparam int IFC_SPC_REBOOT = 7;
   localparam int IFC_SPC_AUX = 4;
   localparam int IFC_SPC_LOC = 1;
   localparam int IFC_SPC_PEN = 0;
   localparam logic [7:0] IFC_SPC_WMASK = 8'h13; // writable bits: 4, 1, 0
   // command byte fields
   localparam int IFC_CMD_BANK = 6;
   localparam int IFC_CMD_OE = 5;
   localparam int IFC_CMD_CE = 4;
   localparam logic [7:0] IFC_CMD_WMASK = 8'h7f; // bit 7 reserved
   localparam logic [3:0] IFC_OP_ERASE = 4'h2;
   localparam logic [3:0] IFC_OP_PROG = 4'h1;
   localparam logic [3:0] IFC_OP_READ = 4'h0;
   // idle register bits
   localparam int IFC_IDLE_ENTER = 0;
   localparam int IFC_IDLE_WAKE = 1;
   // flash geometry
   localparam int IFC_MAIN_BYTES = 32768;
   localparam int IFC_LDR_BYTES = 4096;
   localparam logic [15:0] IFC_PC_RESET = 16'h0000;
   localparam logic [7:0] IFC_ERASED = 8'hff;
   // timing: time per byte step of an operation
   localparam int IFC_STEP_NS = 10;
   localparam int IFC_CLK_NS = 10;
   localparam int IFC_STEP_CYC = (IFC_STEP_NS + IFC_CLK_NS - 1) / IFC_CLK_NS;
   localparam logic [7:0] IFC_BUS_ERR = 8'h00;
   typedef enum logic [2:0] {
      IFC_S_RUN = 3'b000,
      IFC_S_IDLE = 3'b001,
      IFC_S_EXEC = 3'b010,
      IFC_S_ERASE = 3'b011,
      IFC_S_WAKE = 3'b100
   } ifc_state_t;
endpackage

// ===== ifc_isp_flash_control.sv
// module: in-system programming flash sequencer with a classic wishbone register slave
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
module ifc_isp_flash_control
   import ifc_pkg::*;
#(
   parameter int MAIN_BYTES = IFC_MAIN_BYTES,
   parameter int LDR_BYTES = IFC_LDR_BYTES
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // boot strap pin, sampled at reset release
   input wire logic forced_loader_boot_pin,
   // core side
   output logic aux_ram_enable,
   output logic fetch_from_loader,
   output logic pc_clear,
   output logic soft_reset,
   output logic isp_busy
);
   localparam int MAW = $clog2(MAIN_BYTES);
   localparam int LAW = $clog2(LDR_BYTES);

   logic [7:0] spc_q, cmd_q, ah_q, al_q, fd_q;
   logic key_stage_q, unlocked_q;
   logic boot_s1_q, boot_s2_q, forced_boot_q, strap_taken_q;
   logic isp_mode_q, loader_run_q;
   logic idle_q, op_pending_q;
   logic [7:0] main_mem_q [MAIN_BYTES];
   logic [7:0] ldr_mem_q [LDR_BYTES];
   logic [15:0] erase_idx_q;
   logic [7:0] step_q;
   ifc_state_t state_q;
   logic wr, rd, fire_reboot;
   logic [7:0] wbyte, rdata;
   logic [15:0] tgt_addr;
   logic op_ok;

   // single-cycle decode of a wishbone request, lane 0 select needed for writes only
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
   assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
   assign wbyte = wb_dat_i[7:0];
   assign tgt_addr = {ah_q, al_q};

   // true when the command byte is a legal, permitted operation
   function automatic logic cmd_legal(input logic [7:0] c, input logic pen);
      logic [3:0] op;
      op = c[3:0];
      if (c[IFC_CMD_CE]) begin
         cmd_legal = 1'b0;
      end else if (op == IFC_OP_READ) begin
         cmd_legal = !c[IFC_CMD_OE];
      end else if (op == IFC_OP_ERASE || op == IFC_OP_PROG) begin
         cmd_legal = c[IFC_CMD_OE] && pen;
      end else begin
         cmd_legal = 1'b0;
      end
   endfunction

   function automatic logic is_reg(input logic [9:0] a, input logic [7:0] idx);
      is_reg = (a[1:0] == 2'b00) && (a[9:2] == idx);
   endfunction

   assign op_ok = cmd_legal(cmd_q, spc_q[IFC_SPC_PEN]);
   assign fire_reboot = wr && unlocked_q && is_reg(wb_adr_i, IFC_IDX_SPC) && wbyte[IFC_SPC_REBOOT]
      && wbyte[IFC_SPC_LOC] && wbyte[IFC_SPC_PEN];

   // strap synchroniser keeps running through reset so the pin level is settled at release
   always_ff @(posedge ref_clk) begin
      boot_s1_q <= forced_loader_boot_pin;
      boot_s2_q <= boot_s1_q;
   end

   // strap capture once after reset release
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         strap_taken_q <= 1'b0;
         forced_boot_q <= 1'b0;
      end else begin
         if (!strap_taken_q) begin
            strap_taken_q <= 1'b1;
            forced_boot_q <= boot_s2_q;
         end
      end
   end

   // unlock key sequencer
   always_ff @(posedge ref_clk) begin
      if (!rst_b || soft_reset) begin
         key_stage_q <= 1'b0;
         unlocked_q <= 1'b0;
      end else if (wr && is_reg(wb_adr_i, IFC_IDX_KEY)) begin
         key_stage_q <= (wbyte == IFC_KEY1);
         unlocked_q <= key_stage_q && (wbyte == IFC_KEY2);
      end
   end

   // system programming control register and soft reboot
   always_ff @(posedge ref_clk) begin
      if (!rst_b || soft_reset) begin
         spc_q <= 8'h00;
         soft_reset <= 1'b0;
      end else begin
         soft_reset <= fire_reboot;
         if (wr && unlocked_q && is_reg(wb_adr_i, IFC_IDX_SPC)) begin
            spc_q <= wbyte & IFC_SPC_WMASK;
         end
      end
   end

   // address and command registers
   always_ff @(posedge ref_clk) begin
      if (!rst_b || soft_reset) begin
         ah_q <= 8'h00;
         al_q <= 8'h00;
         cmd_q <= 8'h00;
      end else if (wr) begin
         if (is_reg(wb_adr_i, IFC_IDX_AH)) ah_q <= wbyte;
         if (is_reg(wb_adr_i, IFC_IDX_AL)) al_q <= wbyte;
         if (is_reg(wb_adr_i, IFC_IDX_CMD)) cmd_q <= wbyte & IFC_CMD_WMASK;
      end
   end

   // idle and isp sequencer
   always_ff @(posedge ref_clk) begin
      if (!rst_b || soft_reset) begin
         state_q <= IFC_S_RUN;
         idle_q <= 1'b0;
         op_pending_q <= 1'b0;
         isp_mode_q <= 1'b0;
         loader_run_q <= 1'b0;
         pc_clear <= 1'b0;
         isp_busy <= 1'b0;
         erase_idx_q <= 16'h0000;
         step_q <= 8'h00;
      end else begin
         pc_clear <= 1'b0;
         case (state_q)
            IFC_S_RUN: begin
               if (wr && is_reg(wb_adr_i, IFC_IDX_IDLE) && wbyte[IFC_IDLE_ENTER]) begin
                  idle_q <= 1'b1;
                  op_pending_q <= 1'b0;
                  isp_busy <= isp_mode_q && op_ok;
                  erase_idx_q <= 16'h0000;
                  step_q <= 8'h00;
                  state_q <= (isp_mode_q && op_ok) ? IFC_S_EXEC : IFC_S_IDLE;
               end
            end
            IFC_S_EXEC: begin
               if (step_q + 8'd1 >= 8'(IFC_STEP_CYC)) begin
                  if (cmd_q[3:0] == IFC_OP_ERASE) begin
                     state_q <= IFC_S_ERASE;
                  end else begin
                     isp_busy <= 1'b0;
                     state_q <= IFC_S_IDLE;
                  end
               end else begin
                  step_q <= step_q + 8'd1;
               end
            end
            IFC_S_ERASE: begin
               if (erase_idx_q == 16'(cmd_q[IFC_CMD_BANK] ? LDR_BYTES - 1 : MAIN_BYTES - 1)) begin
                  isp_busy <= 1'b0;
                  state_q <= IFC_S_IDLE;
               end else begin
                  erase_idx_q <= erase_idx_q + 16'd1;
               end
            end
            IFC_S_IDLE: begin
               if (op_pending_q) begin
                  state_q <= IFC_S_WAKE;
               end
            end
            IFC_S_WAKE: begin
               idle_q <= 1'b0;
               op_pending_q <= 1'b0;
               if (spc_q[IFC_SPC_PEN] && !isp_mode_q) begin
                  isp_mode_q <= 1'b1;
                  if (spc_q[IFC_SPC_LOC] && !loader_run_q) begin
                     loader_run_q <= 1'b1;
                     pc_clear <= 1'b1;
                  end
               end
               state_q <= IFC_S_RUN;
            end
            default: state_q <= IFC_S_RUN;
         endcase
         // a wake write wins over a clear in the same cycle
         if (wr && is_reg(wb_adr_i, IFC_IDX_IDLE) && wbyte[IFC_IDLE_WAKE]) begin
            op_pending_q <= 1'b1; // wake seen, may arrive during an operation
         end
      end
   end

   // flash arrays and data byte: program, read and erase
   always_ff @(posedge ref_clk) begin
      if (!rst_b || soft_reset) begin
         fd_q <= 8'h00;
      end else begin
         if (wr && is_reg(wb_adr_i, IFC_IDX_FD)) fd_q <= wbyte;
         if (state_q == IFC_S_EXEC && step_q + 8'd1 >= 8'(IFC_STEP_CYC)) begin
            if (cmd_q[3:0] == IFC_OP_PROG) begin
               if (cmd_q[IFC_CMD_BANK]) ldr_mem_q[tgt_addr[LAW-1:0]] <= fd_q;
               else main_mem_q[tgt_addr[MAW-1:0]] <= fd_q;
            end else if (cmd_q[3:0] == IFC_OP_READ) begin
               fd_q <= cmd_q[IFC_CMD_BANK] ? ldr_mem_q[tgt_addr[LAW-1:0]] : main_mem_q[tgt_addr[MAW-1:0]];
            end
         end
         if (state_q == IFC_S_ERASE) begin
            if (cmd_q[IFC_CMD_BANK]) ldr_mem_q[erase_idx_q[LAW-1:0]] <= IFC_ERASED;
            else main_mem_q[erase_idx_q[MAW-1:0]] <= IFC_ERASED;
         end
      end
   end

   // read mux
   always_comb begin
      rdata = IFC_BUS_ERR;
      if (is_reg(wb_adr_i, IFC_IDX_SPC)) rdata = {forced_boot_q, spc_q[6:0]};
      else if (is_reg(wb_adr_i, IFC_IDX_CMD)) rdata = cmd_q;
      else if (is_reg(wb_adr_i, IFC_IDX_AH)) rdata = ah_q;
      else if (is_reg(wb_adr_i, IFC_IDX_AL)) rdata = al_q;
      else if (is_reg(wb_adr_i, IFC_IDX_FD)) rdata = fd_q;
      else if (is_reg(wb_adr_i, IFC_IDX_KEY)) rdata = {7'h00, unlocked_q};
      else if (is_reg(wb_adr_i, IFC_IDX_IDLE)) rdata = {5'h00, isp_busy, isp_mode_q, idle_q};
   end

   // wishbone answer one cycle after the request
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wr || rd || (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o);
         wb_dat_o <= rd ? {24'h000000, rdata} : 32'h0000_0000;
      end
   end

   // core-side outputs
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         aux_ram_enable <= 1'b0;
         fetch_from_loader <= 1'b0;
      end else begin
         aux_ram_enable <= spc_q[IFC_SPC_AUX];
         fetch_from_loader <= forced_boot_q || loader_run_q;
      end
   end
endmodule

// ===== ifc_isp_flash_control_checker.sv
// checker: bus timing and core-side output assertions for the isp flash control block
`timescale 1ns/1ps
module ifc_checker
   import ifc_pkg::*;
(
   // clock, reset and bus
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // core side
   input wire logic aux_ram_enable,
   input wire logic pc_clear,
   input wire logic soft_reset,
   input wire logic isp_busy
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // write requests to the control and idle registers
   wire logic req = wb_cyc_i && wb_stb_i && wb_we_i;
   wire logic spc_wr = req && wb_adr_i == {IFC_IDX_SPC, 2'b00};
   wire logic idle_wr = req && wb_adr_i == {IFC_IDX_IDLE, 2'b00} && wb_dat_i[IFC_IDLE_ENTER];
   wire logic boot_wr = spc_wr && wb_dat_i[7] && wb_dat_i[1] && wb_dat_i[0];
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside ack");
   AST_DAT_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
      else $error("upper read data not zero");
   AST_AUX_CAUSE: assert property ($changed(aux_ram_enable) |-> $past(spc_wr) || $past(spc_wr, 2))
      else $error("aux ram enable changed without control write");
   AST_REBOOT_CAUSE: assert property (soft_reset |-> $past(boot_wr))
      else $error("soft reset without reboot write");
   AST_REBOOT_PULSE: assert property (soft_reset |=> !soft_reset)
      else $error("soft reset longer than one cycle");
   AST_PC_PULSE: assert property (pc_clear |=> !pc_clear)
      else $error("pc clear longer than one cycle");
   AST_BUSY_CAUSE: assert property ($rose(isp_busy) |-> $past(idle_wr) || $past(idle_wr, 2))
      else $error("operation started outside idle entry");
   AST_BUSY_BOUND: assert property ($rose(isp_busy) |-> ##[1:200] !isp_busy)
      else $error("operation never completed");
   // main scenarios reached
   cover property (soft_reset);
   cover property (pc_clear);
   cover property ($rose(isp_busy));
endmodule
bind ifc_isp_flash_control ifc_checker u_chk (.ref_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_dat_i, .wb_dat_o, .wb_ack_o, .aux_ram_enable, .pc_clear, .soft_reset, .isp_busy);

// ===== ifc_testbench.sv
// testbench: random and corner-case register traffic for the isp flash control block
`timescale 1ns/1ps
module testbench;
   import ifc_pkg::*;
   logic ref_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, boot_pin, b;
   logic aux_ram_enable, fetch_from_loader, pc_clear, soft_reset, isp_busy;
   logic [9:0] wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [7:0] rd_v, a, d;
   int errors = 0, checks = 0, n;
   int pc_seen = 0, sr_seen = 0;
   ifc_isp_flash_control #(.MAIN_BYTES(64), .LDR_BYTES(16)) DUT (.ref_clk, .rst_b, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .forced_loader_boot_pin(boot_pin),
      .aux_ram_enable, .fetch_from_loader, .pc_clear, .soft_reset, .isp_busy);
   // count one-cycle pulses of the core-side strobes
   always @(posedge ref_clk) begin
      if (pc_clear === 1'b1) pc_seen++;
      if (soft_reset === 1'b1) sr_seen++;
   end
   // clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // verdict
   task automatic end_of_test();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   // one classic wishbone cycle, read byte left in rd_v
   task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] dat);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_dat_i <= {24'h00_0000, dat};
      do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
      rd_v = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge ref_clk);
   endtask
   // synchronous reset held six cycles
   task automatic do_reset();
      rst_b <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge ref_clk);
   endtask
   // command byte: output enable only for erase and program, chip enable low
   function automatic logic [7:0] cmd_of(input logic bank, input logic [3:0] op);
      return {1'b0, bank, op != IFC_OP_READ, 1'b0, op};
   endfunction
   // one flash operation run inside idle, then wake
   task automatic run_op(input logic [7:0] cmd, input logic [7:0] ad, input logic [7:0] dt);
      bus(1'b1, IFC_IDX_AH, 8'h00);
      bus(1'b1, IFC_IDX_AL, ad);
      bus(1'b1, IFC_IDX_FD, dt);
      bus(1'b1, IFC_IDX_CMD, cmd);
      bus(1'b1, IFC_IDX_IDLE, 8'h01);
      n = 0;
      while (isp_busy === 1'b1 && n < 300) begin
         @(posedge ref_clk);
         n++;
      end
      bus(1'b1, IFC_IDX_IDLE, 8'h02);
   endtask
   // read one byte back through a read operation
   task automatic rd_flash(input logic bank, input logic [7:0] ad, input logic [7:0] exp, input string what);
      run_op(cmd_of(bank, IFC_OP_READ), ad, ~exp);
      bus(1'b0, IFC_IDX_FD, 8'h00);
      chk(rd_v, exp, what);
   endtask
   // unlock the control register
   task automatic unlock();
      bus(1'b1, IFC_IDX_KEY, IFC_KEY1);
      bus(1'b1, IFC_IDX_KEY, IFC_KEY2);
   endtask
   // hang guard
   initial begin
      #200000;
      errors++;
      end_of_test();
   end
   // main sequence
   initial begin
      {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, boot_pin, wb_adr_i, wb_dat_i} = '0;
      void'($urandom(32'h6a832942));
      do_reset();
      chk(fetch_from_loader, 1'b0, "boot bank");
      bus(1'b1, IFC_IDX_SPC, 8'h13);
      bus(1'b0, IFC_IDX_SPC, 8'h00);
      chk(rd_v, 8'h00, "locked control");
      bus(1'b0, 8'h01, 8'h00);
      chk(rd_v, 8'h00, "unmapped read");
      unlock();
      bus(1'b0, IFC_IDX_KEY, 8'h00);
      chk(rd_v[0], 1'b1, "unlock flag");
      bus(1'b1, IFC_IDX_SPC, 8'h1f);
      bus(1'b0, IFC_IDX_SPC, 8'h00);
      chk(rd_v, 8'h13, "control fields");
      chk(aux_ram_enable, 1'b1, "aux ram");
      bus(1'b1, IFC_IDX_KEY, 8'h00);
      bus(1'b1, IFC_IDX_SPC, 8'h00);
      bus(1'b0, IFC_IDX_SPC, 8'h00);
      chk(rd_v, 8'h13, "relocked control");
      bus(1'b1, IFC_IDX_IDLE, 8'h01);
      bus(1'b1, IFC_IDX_IDLE, 8'h02);
      bus(1'b0, IFC_IDX_IDLE, 8'h00);
      chk(rd_v[1], 1'b1, "isp mode");
      chk(fetch_from_loader, 1'b1, "loader location");
      chk(8'(pc_seen), 8'h01, "pc clear pulses");
      run_op(cmd_of(1'b0, IFC_OP_ERASE), 8'h33, 8'h00);
      run_op(cmd_of(1'b1, IFC_OP_ERASE), 8'h05, 8'h00);
      rd_flash(1'b0, 8'h00, IFC_ERASED, "erased main");
      for (int i = 0; i < 12; i++) begin
         b = 1'($urandom_range(1));
         a = b ? 8'(i + 4) : 8'(i + 52);
         d = (i == 0) ? 8'h00 : 8'($urandom);
         run_op(cmd_of(b, IFC_OP_PROG), a, d);
         rd_flash(b, a, d, "programmed byte");
      end
      run_op(8'h01, 8'h00, 8'h5a);
      rd_flash(1'b0, 8'h00, IFC_ERASED, "program without oe");
      run_op(8'h31, 8'h01, 8'h5a);
      rd_flash(1'b0, 8'h01, IFC_ERASED, "program with ce");
      unlock();
      bus(1'b1, IFC_IDX_SPC, 8'h12);
      run_op(cmd_of(1'b0, IFC_OP_PROG), 8'h02, 8'h5a);
      rd_flash(1'b0, 8'h02, IFC_ERASED, "program disabled");
      bus(1'b1, IFC_IDX_SPC, 8'h81);
      bus(1'b0, IFC_IDX_SPC, 8'h00);
      chk(rd_v, 8'h01, "no reboot without location bit");
      bus(1'b1, IFC_IDX_SPC, 8'h93);
      bus(1'b0, IFC_IDX_SPC, 8'h00);
      chk(rd_v, 8'h00, "control after reboot");
      chk(aux_ram_enable, 1'b0, "aux after reboot");
      chk(8'(sr_seen), 8'h01, "soft reset pulses");
      boot_pin <= 1'b1;
      do_reset();
      bus(1'b0, IFC_IDX_SPC, 8'h00);
      chk(rd_v[7], 1'b1, "forced boot flag");
      chk(fetch_from_loader, 1'b1, "forced boot fetch");
      end_of_test();
   end
endmodule
